// ### rtl/tgp_pkg.sv
// Purpose: shared constants, carriers and decoders for gate pulse timing
// Assumes: one system clock; the timing clock arrives as a pin level
// Notes:   step counts six 60-degree sectors of one mains cycle
package tgp_pkg;
  localparam int VCO_PER_MAINS = 384;
  localparam int SIX_DIV       = 64;
  localparam int STEPS         = VCO_PER_MAINS / SIX_DIV;
  localparam int DIV_W         = $clog2(SIX_DIV);
  localparam int STEP_W        = 3;
  localparam int NUM_PH        = 3;
  localparam int NUM_GATES     = 6;
  localparam int REF_STEPS     = STEPS / 2;
  localparam logic [DIV_W-1:0]  DIV_LAST   = DIV_W'(SIX_DIV - 1);
  localparam logic [DIV_W-1:0]  DIV_RESET  = 6'h00;
  localparam logic [STEP_W-1:0] STEP_LAST  = STEP_W'(STEPS - 1);
  localparam logic [STEP_W-1:0] STEP_RESET = 3'h0;

  typedef struct packed {
    logic instant_enable;
    logic soft_enable_n;
    logic phase_loss;
    logic delay_at_max;
    logic single_burst;
  } tgp_ctl_t;

  typedef struct packed {
    logic ramp_out_req;
    logic gating_enabled;
  } tgp_status_t;

  typedef enum logic [1:0] {TGP_RUN, TGP_RAMP, TGP_INH} tgp_soft_t;

  // gate k conducts in sectors k and k+1, a 120-degree window
  function automatic logic tgp_in_window(input logic [STEP_W-1:0] step, input int k);
    logic [STEP_W-1:0] first;
    logic [STEP_W-1:0] second;
    first  = STEP_W'(k);
    second = (k == STEPS - 1) ? STEP_RESET : STEP_W'(k + 1);
    return (step == first) || (step == second);
  endfunction

  // phase reference ph is high for three sectors from sector 2*ph
  function automatic logic tgp_ref_high(input logic [STEP_W-1:0] step, input int ph);
    int d;
    d = int'(step) - 2 * ph;
    if (d < 0) begin
      d = d + STEPS;
    end
    return d < REF_STEPS;
  endfunction
endpackage

// ### rtl/tgp_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: bits are independent levels
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module tgp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
    end else if (ce) begin
      ff1_reg <= d;
      ff2_reg <= ff1_reg;
    end
  end

  assign q = ff2_reg;
endmodule
`default_nettype wire

// ### rtl/tgp_phase_gen.sv
// Purpose: divide timing ticks into the 6f clock and delayed 1f references
// Assumes: vco_tick is a one-cycle pulse per timing clock fall
// Notes:   outputs lag the counters by one tick, just under one degree
`timescale 1ns/1ps
`default_nettype none
module tgp_phase_gen
  import tgp_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       ce,
  input  wire logic                       vco_tick,
  output logic                            six_clk,
  output logic [tgp_pkg::STEP_W-1:0]      step_dly,
  output logic [tgp_pkg::NUM_PH-1:0]      refs
);
  logic [DIV_W-1:0]  div_reg, div_next;
  logic [STEP_W-1:0] step_reg, step_next;
  logic [STEP_W-1:0] stepd_reg, stepd_next;
  logic [NUM_PH-1:0] refs_reg, refs_next;
  logic              six_reg, six_next;

  always_comb begin
    div_next   = div_reg;
    step_next  = step_reg;
    stepd_next = stepd_reg;
    refs_next  = refs_reg;
    six_next   = six_reg;
    if (vco_tick) begin
      div_next   = (div_reg == DIV_LAST) ? DIV_RESET : div_reg + 1'b1;
      if (div_reg == DIV_LAST) begin
        step_next = (step_reg == STEP_LAST) ? STEP_RESET : step_reg + 1'b1;
      end
      six_next   = ~div_reg[DIV_W-1];
      stepd_next = step_reg;
      for (int p = 0; p < NUM_PH; p++) begin
        refs_next[p] = tgp_ref_high(step_reg, p);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg   <= DIV_RESET;
      step_reg  <= STEP_RESET;
      stepd_reg <= STEP_RESET;
      refs_reg  <= 3'h0;
      six_reg   <= 1'b0;
    end else if (ce) begin
      div_reg   <= div_next;
      step_reg  <= step_next;
      stepd_reg <= stepd_next;
      refs_reg  <= refs_next;
      six_reg   <= six_next;
    end
  end

  assign six_clk  = six_reg;
  assign step_dly = stepd_reg;
  assign refs     = refs_reg;

  property p_div64;
    @(posedge clk) disable iff (reset || !ce)
    (vco_tick && div_reg == DIV_LAST) |=> (step_reg != $past(step_reg));
  endproperty
  a_div64: assert property (p_div64) else $error("sector did not advance after 64 ticks");

  property p_ref_spread;
    @(posedge clk) disable iff (reset || !ce)
    $rose(refs_reg[1]) |-> (stepd_reg == 3'h2) && refs_reg[0] && !refs_reg[2];
  endproperty
  a_ref_spread: assert property (p_ref_spread) else $error("all references high at once");
endmodule
`default_nettype wire

// ### rtl/tgp_gate_timing.sv
// Purpose: digital gate delay timing for a three-phase thyristor bridge
// Assumes: timing clock, mains references and control are pin levels
// Notes:   gate outputs are full-width pulse commands for the amplifiers
//
// Overview of operation
// - divide 384x timing clock by 64
// - divide by six into three delayed references
// - two-burst: references AND timing AND 6f
// - each pulse half a timing period
// - second burst sixty degrees after first
// - single burst: references AND timing only
// - profile selectable by a pin
// - three XOR phase detector outputs
// - swap comparator references on reverse rotation
// - six gate command outputs
// - instant enable gates and inhibits at the next pulse gap
// - soft inhibit waits for maximum delay
`timescale 1ns/1ps
`default_nettype none
module tgp_gate_timing
  import tgp_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  input  wire logic                          vco_clk_in,
  input  wire logic [tgp_pkg::NUM_PH-1:0]    mains_ref,
  input  wire tgp_pkg::tgp_ctl_t             ctl,
  output logic      [tgp_pkg::NUM_GATES-1:0] gate_cmd,
  output logic      [tgp_pkg::NUM_PH-1:0]    phase_det,
  output logic                               six_times_mains_clock,
  output var tgp_pkg::tgp_status_t           status
);
  import tgp_pkg::*;

  localparam int SYNC_W = 1 + NUM_PH + $bits(tgp_ctl_t);

  logic [SYNC_W-1:0]  sync_q;
  logic               vco_s;
  logic [NUM_PH-1:0]  mains_s;
  tgp_ctl_t           ctl_s;
  logic               vco_tick;
  logic               six_clk;
  logic [STEP_W-1:0]  step_dly;
  logic [NUM_PH-1:0]  refs;
  logic [NUM_PH-1:0]  sel_ref;

  // timing clock, references and control all cross from pins
  tgp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     ({vco_clk_in, mains_ref, ctl}),
    .q     (sync_q)
  );

  assign vco_s   = sync_q[SYNC_W-1];
  assign mains_s = sync_q[SYNC_W-2 -: NUM_PH];
  assign ctl_s   = sync_q[$bits(tgp_ctl_t)-1:0];

  // edge and rotation state
  logic vco_q_reg, vco_q_next;
  logic ma_q_reg, ma_q_next;
  logic rev_reg, rev_next;

  always_comb begin
    vco_q_next = vco_s;
    ma_q_next  = mains_s[0];
    rev_next   = rev_reg;
    // at a rise of A, B already high means C-B-A rotation
    if (mains_s[0] && !ma_q_reg) begin
      rev_next = mains_s[1];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vco_q_reg <= 1'b0;
      ma_q_reg  <= 1'b0;
      rev_reg   <= 1'b0;
    end else if (ce) begin
      vco_q_reg <= vco_q_next;
      ma_q_reg  <= ma_q_next;
      rev_reg   <= rev_next;
    end
  end

  // advance on the timing clock fall: sector and 6f settle in the pulse gap,
  // so no pulse is clipped where a burst starts or ends
  assign vco_tick = !vco_s && vco_q_reg;

  tgp_phase_gen u_phase (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .vco_tick (vco_tick),
    .six_clk  (six_clk),
    .step_dly (step_dly),
    .refs     (refs)
  );

  assign six_times_mains_clock = six_clk;

  // references arrive already shifted by 30 degrees, so they compare direct
  assign sel_ref = rev_reg ? {mains_s[1], mains_s[2], mains_s[0]} : mains_s;

  // soft enable state
  tgp_soft_t st_reg, st_next;
  logic      soft_ok;

  assign soft_ok = !ctl_s.soft_enable_n && !ctl_s.phase_loss;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      TGP_RUN: begin
        if (!soft_ok) begin
          st_next = TGP_RAMP;
        end
      end
      TGP_RAMP: begin
        if (soft_ok) begin
          st_next = TGP_RUN;
        end else if (ctl_s.delay_at_max) begin
          st_next = TGP_INH;
        end
      end
      TGP_INH: begin
        if (soft_ok) begin
          st_next = TGP_RUN;
        end
      end
      default: begin
        st_next = TGP_INH;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= TGP_INH;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // gating permission moves only between pulses, trading up to half a
  // timing period of latency for never clipping a pulse
  logic allow_reg, allow_next;
  logic allow_want;

  assign allow_want = ctl_s.instant_enable && (st_reg != TGP_INH);

  always_comb begin
    allow_next = allow_reg;
    if (!vco_s) begin
      allow_next = allow_want;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      allow_reg <= 1'b0;
    end else if (ce) begin
      allow_reg <= allow_next;
    end
  end

  // gate commands and phase detectors
  logic [NUM_GATES-1:0] gate_reg, gate_next;
  logic [NUM_GATES-1:0] win;
  logic [NUM_PH-1:0]    pd_reg, pd_next;
  logic                 burst_clk;

  // single burst ignores the 6f clock, giving 128 pulses in 120 degrees
  assign burst_clk = ctl_s.single_burst ? 1'b1 : six_clk;

  generate
    for (genvar k = 0; k < NUM_GATES; k++) begin : g_gate
      assign win[k] = tgp_in_window(step_dly, k);
    end
  endgenerate

  always_comb begin
    gate_next = win & {NUM_GATES{vco_s && burst_clk && allow_reg}};
    pd_next   = sel_ref ^ refs;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_reg <= 6'h00;
      pd_reg   <= 3'h0;
    end else if (ce) begin
      gate_reg <= gate_next;
      pd_reg   <= pd_next;
    end
  end

  assign gate_cmd  = gate_reg;
  assign phase_det = pd_reg;
  assign status    = '{ramp_out_req: (st_reg != TGP_RUN), gating_enabled: allow_reg};

  // helper: ce held over two cycles keeps past values meaningful
  logic ce_d_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ce_d_reg <= 1'b0;
    end else begin
      ce_d_reg <= ce;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !ce || !ce_d_reg);

  sequence s_gap;
    !vco_s;
  endsequence

  sequence s_blocked;
    !allow_reg ##1 (gate_reg == 6'h00);
  endsequence

  property p_two_burst;
    (|gate_reg && !$past(ctl_s.single_burst)) |-> $past(six_clk) && $past(vco_s);
  endproperty
  a_two_burst: assert property (p_two_burst) else $error("two-burst pulse outside 6f high");

  property p_duty;
    $fell(vco_s) |=> (gate_reg == 6'h00);
  endproperty
  a_duty: assert property (p_duty) else $error("pulse outlived timing half period");

  property p_window;
    gate_reg != 6'h00 |-> ((gate_reg & ~$past(win)) == 6'h00);
  endproperty
  a_window: assert property (p_window) else $error("gate pulse outside its window");

  property p_single;
    (ctl_s.single_burst && vco_s && allow_reg && win[0]) |=> gate_reg[0];
  endproperty
  a_single: assert property (p_single) else $error("single burst pulse missing");

  property p_pd;
    pd_reg == ($past(sel_ref) ^ $past(refs));
  endproperty
  a_pd: assert property (p_pd) else $error("phase detector mismatch");

  property p_rev;
    rev_reg |-> (sel_ref[1] == mains_s[2]) && (sel_ref[2] == mains_s[1]);
  endproperty
  a_rev: assert property (p_rev) else $error("reference swap wrong for rotation");

  property p_instant;
    (!ctl_s.instant_enable && !$past(ctl_s.instant_enable)) ##0 s_gap |=> s_blocked;
  endproperty
  a_instant: assert property (p_instant) else $error("instant inhibit not taken");

  property p_soft;
    (st_reg == TGP_INH && $past(st_reg) == TGP_RAMP) |-> $past(ctl_s.delay_at_max);
  endproperty
  a_soft: assert property (p_soft) else $error("inhibit before maximum delay");

  property p_no_partial;
    (allow_reg != $past(allow_reg)) |-> !$past(vco_s);
  endproperty
  a_no_partial: assert property (p_no_partial) else $error("permission changed mid pulse");

  property p_hold_off;
    !allow_reg |=> (gate_reg == 6'h00);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("gate active while inhibited");

  property p_gate_pair;
    $countones(gate_reg) <= 2;
  endproperty
  a_gate_pair: assert property (p_gate_pair) else $error("more than two gates active");

  property p_six_block;
    (!ctl_s.single_burst && !six_clk) |=> (gate_reg == 6'h00);
  endproperty
  a_six_block: assert property (p_six_block) else $error("two-burst pulse while 6f low");

  property p_steady;
    (vco_s && $past(vco_s) && $stable(ctl_s.single_burst)) |-> $stable(gate_next);
  endproperty
  a_steady: assert property (p_steady) else $error("gate command changed inside a pulse");

  property p_instant_on;
    (ctl_s.instant_enable && st_reg == TGP_RUN && !vco_s) |=> allow_reg;
  endproperty
  a_instant_on: assert property (p_instant_on) else $error("instant enable not taken");

  property p_ramp_gates;
    (ctl_s.instant_enable && st_reg == TGP_RAMP && !vco_s) |=> allow_reg;
  endproperty
  a_ramp_gates: assert property (p_ramp_gates) else $error("gating stopped during ramp");
endmodule
`default_nettype wire

// ### dv/tgp_amp_model.sv
// Purpose: gate amplifier stand-in that counts and sizes gate pulses
// Assumes: a pulse is counted when its gate command falls
// Notes:   clear only while all gates are low, else a run is cut short
`timescale 1ns/1ps
`default_nettype none
module tgp_amp_model (
  input  wire logic                          clk,
  input  wire logic                          clear,
  input  wire logic [tgp_pkg::NUM_GATES-1:0] gate_cmd,
  output var int                             pulses [tgp_pkg::NUM_GATES],
  output var int                             min_w,
  output var int                             max_w
);
  import tgp_pkg::*;
  int run [NUM_GATES];

  always @(posedge clk) begin
    for (int k = 0; k < NUM_GATES; k++) begin
      if (clear) begin
        pulses[k] = 0;
        run[k]    = 0;
        min_w     = 9999;
        max_w     = 0;
      end else if (gate_cmd[k] === 1'b1) begin
        run[k] = run[k] + 1;
      end else if (run[k] > 0) begin
        // min and max width kept over all pulses so a clipped pulse shows up
        pulses[k] = pulses[k] + 1;
        min_w     = (run[k] < min_w) ? run[k] : min_w;
        max_w     = (run[k] > max_w) ? run[k] : max_w;
        run[k]    = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/tgp_gate_timing_test.sv
// Purpose: self-checking bench for the gate pulse timing block
// Assumes: timing clock period is eight system clocks, one mains cycle 3072
// Notes:   mains references are derived from the same count as the timing clock
`timescale 1ns/1ps
`default_nettype none
module tgp_gate_timing_test;
  import tgp_pkg::*;
  localparam int CYC = VCO_PER_MAINS * 8;
  logic                 clk;
  logic                 reset;
  logic                 ce;
  logic                 clr;
  logic                 vco;
  logic                 six;
  logic [NUM_PH-1:0]    mref;
  logic [NUM_PH-1:0]    phase_det;
  logic [NUM_GATES-1:0] gate_cmd;
  tgp_ctl_t             ctl;
  tgp_status_t          status;
  int                   pulses [NUM_GATES];
  int                   pd_hi [NUM_PH];
  int                   min_w;
  int                   max_w;
  int                   mode;
  int                   tick;
  int                   six_rise;
  int                   failures;
  int                   samples_checked;

  tgp_gate_timing dut (
    .clk(clk), .reset(reset), .ce(ce), .vco_clk_in(vco), .mains_ref(mref), .ctl(ctl),
    .gate_cmd(gate_cmd), .phase_det(phase_det), .six_times_mains_clock(six), .status(status)
  );
  tgp_amp_model amp (
    .clk(clk), .clear(clr), .gate_cmd(gate_cmd), .pulses(pulses), .min_w(min_w), .max_w(max_w)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // 50-percent squares a third of a cycle apart; mode 2 reverses rotation
  always @(posedge clk) begin
    #1;
    tick = (tick + 1) % CYC;
    vco  = tick[2];
    for (int p = 0; p < NUM_PH; p++) begin
      mref[p] = (mode != 0) && (((tick + CYC - (CYC / 3) * ((mode == 1) ? p : (3 - p) % 3)) % CYC) < CYC / 2);
    end
  end

  task automatic report_and_stop();
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(CYC * 10 * 30);
    failures++;
    report_and_stop();
  end

  task automatic chkv(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chki(input string n, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic int near(input int a, input int b);
    return (a - b <= 16) && (b - a <= 16) && (a > 0);
  endfunction

  function automatic int total();
    int s;
    s = 0;
    for (int k = 0; k < NUM_GATES; k++) s += pulses[k];
    return s;
  endfunction

  task automatic clear_model();
    do step(1); while (gate_cmd !== '0);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
  endtask

  // one full mains cycle of model counts, 6f rises and detector high time
  task automatic measure();
    logic prev;
    clear_model();
    prev     = six;
    six_rise = 0;
    pd_hi    = '{default: 0};
    repeat (CYC) begin
      @(posedge clk);
      #2;
      six_rise += int'(six === 1'b1 && prev === 1'b0);
      prev = six;
      for (int p = 0; p < NUM_PH; p++) pd_hi[p] += int'(phase_det[p] === 1'b1);
    end
  endtask

  task automatic t_profile(input logic single, input int n);
    ctl.single_burst = single;
    measure();
    measure();
    for (int k = 0; k < NUM_GATES; k++) chki("pulses", n, pulses[k]);
    chki("min_w", 4, min_w);
    chki("max_w", 4, max_w);
    chki("six_rise", 6, six_rise);
    for (int p = 0; p < NUM_PH; p++) chki("pd_hi", CYC / 2, pd_hi[p]);
  endtask

  task automatic t_rotation(input int m);
    mode = m;
    measure();
    measure();
    chki("pd_01", 1, near(pd_hi[0], pd_hi[1]));
    chki("pd_02", 1, near(pd_hi[0], pd_hi[2]));
    mode = 0;
  endtask

  task automatic t_instant();
    int s;
    logic [NUM_GATES:0] g;
    clear_model();
    step(700);
    ctl.instant_enable = 1'b0;
    step(20);
    chkv("gating_enabled", 0, status.gating_enabled);
    s = total();
    step(700);
    chki("pulses_inhibited", s, total());
    ctl.instant_enable = 1'b1;
    step(20);
    chkv("gating_enabled", 1, status.gating_enabled);
    step(900);
    chki("min_w", 4, min_w);
    chki("max_w", 4, max_w);
    ce = 1'b0;
    step(2);
    g = {six, gate_cmd};
    s = total();
    step(300);
    chkv("frozen_outputs", g, {six, gate_cmd});
    chki("frozen_pulses", s, total());
    ce = 1'b1;
  endtask

  task automatic t_soft(input logic use_loss);
    if (use_loss) ctl.phase_loss = 1'b1;
    else ctl.soft_enable_n = 1'b1;
    step(20);
    chkv("ramp_out_req", 1, status.ramp_out_req);
    chkv("gating_enabled", 1, status.gating_enabled);
    measure();
    chki("pulses_ramp", 128, pulses[0]);
    step(1);
    ctl.delay_at_max = 1'b1;
    step(20);
    chkv("gating_enabled", 0, status.gating_enabled);
    chkv("gate_cmd", 0, gate_cmd);
    ctl.soft_enable_n = 1'b0;
    ctl.phase_loss    = 1'b0;
    ctl.delay_at_max  = 1'b0;
    step(40);
    chkv("ramp_out_req", 0, status.ramp_out_req);
    chkv("gating_enabled", 1, status.gating_enabled);
  endtask

  initial begin
    reset = 1'b1;
    ce    = 1'b1;
    clr   = 1'b0;
    vco   = 1'b0;
    mref  = '0;
    mode  = 0;
    tick  = 0;
    ctl   = '0;
    ctl.instant_enable = 1'b1;
    failures        = 0;
    samples_checked = 0;
    step(5);
    chkv("gate_cmd", 0, gate_cmd);
    chkv("ramp_out_req", 1, status.ramp_out_req);
    step(1);
    reset = 1'b0;
    t_profile(1'b0, 64);
    t_profile(1'b1, 128);
    t_rotation(1);
    t_rotation(2);
    t_instant();
    t_soft(1'b0);
    t_soft(1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
